// ===== bench/hts_i2c_mst.sv
// i2c master model on the far side of the readout
`timescale 1ns/10ps
`default_nettype none
module hts_i2c_mst (
    // clock
    input  wire logic clk_i,
    // bus lines
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_low_o
);
    logic [7:0] rx_q [0:7];  // bytes of the last read frame
    logic       ack_q;       // address acknowledged

    // bus idle: scl stands high, sda released
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    // a quarter of the 320 ns bus period
    task automatic qtr();
        repeat (2) @(posedge clk_i);
    endtask

    // one bit slot: data set while scl low, sampled mid high phase
    task automatic bit_x(input logic b, output logic r);
        sda_low_o <= !b;
        qtr();
        scl_o <= 1'b1;
        qtr();
        r = sda_i;
        qtr();
        scl_o <= 1'b0;
        qtr();
    endtask

    task automatic start();
        sda_low_o <= 1'b1;
        qtr();
        scl_o <= 1'b0;
        qtr();
    endtask

    // stop, then bus free time before any new start
    task automatic stop();
        sda_low_o <= 1'b1;
        qtr();
        scl_o <= 1'b1;
        qtr();
        sda_low_o <= 1'b0;
        repeat (8) qtr();
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask

    // nack on the last byte ends the read
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(last, r);
    endtask

    // address plus write, n payload bytes taken from the top of d
    task automatic wr_frame(input logic [6:0] adr, input int n, input logic [23:0] d);
        logic a;
        start();
        wr_byte({adr, 1'b0}, ack_q);
        for (int i = 0; i < n; i++) wr_byte(d[23 - 8 * i -: 8], a);
        stop();
    endtask

    // address plus read, n bytes, nack then stop
    task automatic rd_frame(input logic [6:0] adr, input int n);
        start();
        wr_byte({adr, 1'b1}, ack_q);
        for (int i = 0; i < n; i++) rd_byte(i == n - 1, rx_q[i]);
        stop();
    endtask
endmodule // hts_i2c_mst
`default_nettype wire

// ===== bench/hts_top_sva.sv
// port-level checker of the sensor readout
`timescale 1ns/10ps
`default_nettype none
module hts_top_sva #(
    parameter [31:0] PROG_WIN_CYC = 32'd250000
) (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    // bus pins
    input wire logic        scl_i,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe_o,
    // samples and status
    input wire logic [13:0] hum_raw_i,
    input wire logic [13:0] tmp_raw_i,
    input wire logic        meas_busy_o,
    input wire logic        prog_mode_o
);
    logic [31:0] rst_cnt_reg;   // cycles since reset release, saturating
    logic [31:0] stop_cnt_reg;  // cycles since the last stop on the wire
    logic [19:0] busy_cnt_reg;  // length of the running busy phase
    logic        sda_q_reg;     // sda one cycle ago
    logic        len_ok;        // busy phase fits one table total

    // helper counters; a stop is sda rising while scl is high
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_cnt_reg  <= 32'h0;
            stop_cnt_reg <= 32'hffff_ffff;
            busy_cnt_reg <= 20'h0;
            sda_q_reg    <= 1'b1;
        end else begin
            sda_q_reg    <= sda_i;
            rst_cnt_reg  <= (&rst_cnt_reg) ? rst_cnt_reg : rst_cnt_reg + 32'h1;
            stop_cnt_reg <= (scl_i && sda_i && !sda_q_reg) ? 32'h0 :
                            (&stop_cnt_reg) ? stop_cnt_reg : stop_cnt_reg + 32'h1;
            busy_cnt_reg <= meas_busy_o ? busy_cnt_reg + 20'h1 : 20'h0;
        end
    end

    // wrap-around compare gives a window of 16 cycles around each total
    assign len_ok = (busy_cnt_reg - 20'd29992 <= 20'd16) || (busy_cnt_reg - 20'd67992 <= 20'd16) ||
                    (busy_cnt_reg - 20'd227492 <= 20'd16) || (busy_cnt_reg - 20'd847492 <= 20'd16);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_stop_seen;
        stop_cnt_reg <= 32'd8;
    endsequence
    sequence s_busy_min;
        meas_busy_o [*8];
    endsequence

    a_busy_on_request: assert property ($rose(meas_busy_o) |-> s_stop_seen ##0 !prog_mode_o)
        else $error("conversion started without a request");
    a_busy_hold: assert property ($rose(meas_busy_o) |-> s_busy_min)
        else $error("conversion cut short");
    a_busy_length: assert property ($fell(meas_busy_o) |-> len_ok)
        else $error("busy phase length not a table value");
    a_sda_steady: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("sda drive changed while scl high");
    a_open_drain: assert property (!sda_o)
        else $error("sda drive value not low");
    a_prog_no_meas: assert property (prog_mode_o |-> !meas_busy_o)
        else $error("conversion during programming mode");
    a_prog_entry: assert property ($rose(prog_mode_o) |-> stop_cnt_reg <= 32'd3008)
        else $error("programming entry too slow");
    a_prog_window: assert property ($rose(prog_mode_o) |-> rst_cnt_reg <= PROG_WIN_CYC + 32'd3100)
        else $error("programming entered after window");
    a_prog_exit: assert property ($fell(prog_mode_o) |-> s_stop_seen)
        else $error("programming left without a frame");
endmodule // hts_top_sva

bind hts_top hts_top_sva #(.PROG_WIN_CYC(PROG_WIN_CYC)) u_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .hum_raw_i(hum_raw_i), .tmp_raw_i(tmp_raw_i), .meas_busy_o(meas_busy_o), .prog_mode_o(prog_mode_o)
);
`default_nettype wire

// ===== bench/hts_top_test.sv
// self-checking bench of the sensor readout
`timescale 1ns/10ps
`include "hts_regs.vh"
`default_nettype none
module hts_top_test;
    localparam logic [31:0] ID = 32'h3c96a55a;  // arbitrary value
    localparam int          PW = 4000;          // shortened programming window
    localparam logic [6:0]  AD = `HTS_SLAVE_ADDR;
    logic        clk_i;        // 25 mhz clock
    logic        rst_n_i;      // async reset
    logic [13:0] hum_raw_i;    // humidity sample
    logic [13:0] tmp_raw_i;    // temperature sample
    wire         scl;          // bus clock from the master
    wire         m_low;        // master pulls sda low
    wire         sd_o;         // open-drain drive value, must stay low
    wire         sda_oe_o;     // device pulls sda low
    wire         meas_busy_o;  // conversion running
    wire         prog_mode_o;  // programming mode
    wire         sda = !(m_low || sda_oe_o);  // open drain with pull-up
    int          err_count;
    int          checks;
    logic [47:0] rows [0:5];   // write reg, write word, read reg, read word

    hts_top #(.SENSOR_ID(ID), .PROG_WIN_CYC(PW)) uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sd_o), .sda_oe_o(sda_oe_o),
        .hum_raw_i(hum_raw_i), .tmp_raw_i(tmp_raw_i), .meas_busy_o(meas_busy_o), .prog_mode_o(prog_mode_o));
    hts_i2c_mst mst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = !clk_i;
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // fetch n bytes; data compared only when v is set
    task automatic fetch(input int n, input logic [1:0] st, input logic [13:0] h, input logic [13:0] t,
                         input logic v);
        mst.rd_frame(AD, n);
        chk("fetch ack", 16'h1, {15'h0, mst.ack_q});
        chk("sda drive value", 16'h0, {15'h0, sd_o});
        chk("status", {14'h0, st}, {14'h0, mst.rx_q[0][7:6]});
        if (v) begin
            chk("humidity", {2'b00, h}, {2'b00, mst.rx_q[0][5:0], mst.rx_q[1]});
            if (n > 2) chk("temp high", {8'h0, t[13:6]}, {8'h0, mst.rx_q[2]});
            if (n > 3) chk("temp low", {10'h0, t[5:0]}, {10'h0, mst.rx_q[3][7:2]});
            if (n > 4) chk("pad byte", 16'h0, {8'h0, mst.rx_q[4]});
        end
    endtask

    // pointer write, then two-byte read, msb byte first
    task automatic nv_read(input logic [7:0] ra, output logic [15:0] w);
        mst.wr_frame(AD, 1, {ra, 16'h0});
        mst.rd_frame(AD, 2);
        w = {mst.rx_q[0], mst.rx_q[1]};
    endtask

    // watchdog well beyond one 8-bit measurement plus setup
    initial begin
        repeat (60000) @(posedge clk_i);
        err_count++;
        $display("BAD watchdog expected finish seen timeout");
        end_sim();
    end

    initial begin
        logic [15:0] w;
        err_count = 0;
        checks = 0;
        rst_n_i = 1'b0;
        hum_raw_i = 14'h2a5c;
        tmp_raw_i = 14'h1397;
        // resolution cleared to 8 bits by read-modify-write keeps the run short
        rows[0] = {8'h00, 16'h0, `HTS_REG_HRES_RD, `HTS_NVM_RESET};
        rows[1] = {8'h00, 16'h0, `HTS_REG_TRES_RD, `HTS_NVM_RESET};
        rows[2] = {8'h00, 16'h0, `HTS_REG_ID_HI, ID[31:16]};
        rows[3] = {8'h00, 16'h0, `HTS_REG_ID_LO, ID[15:0]};
        rows[4] = {`HTS_REG_HRES_WR, `HTS_NVM_RESET & 16'hf3ff, `HTS_REG_HRES_RD, 16'h0000};
        rows[5] = {`HTS_REG_TRES_WR, `HTS_NVM_RESET & 16'hf3ff, `HTS_REG_TRES_RD, 16'h0000};
        repeat (5) @(posedge clk_i);
        chk("reset outputs", 16'h0, {12'h0, sd_o, sda_oe_o, meas_busy_o, prog_mode_o});
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        fetch(3, `HTS_STAT_STALE, 14'h0, 14'h0, 1'b0);
        // foreign address: no acknowledge, nothing started
        mst.wr_frame(AD ^ 7'h01, 0, 24'h0);
        chk("foreign ack", 16'h0, {15'h0, mst.ack_q});
        chk("foreign busy", 16'h0, {15'h0, meas_busy_o});
        mst.wr_frame(AD, 2, {`HTS_CMD_PROG_ENTER, `HTS_CMD_ZERO, 8'h00});
        repeat (3000) @(posedge clk_i);
        chk("prog mode", 16'h1, {15'h0, prog_mode_o});
        foreach (rows[i]) begin
            if (rows[i][47:40] != 8'h00) mst.wr_frame(AD, 3, rows[i][47:24]);
            nv_read(rows[i][23:16], w);
            chk("nv word", rows[i][15:0], w);
        end
        mst.wr_frame(AD, 3, {`HTS_CMD_PROG_EXIT, `HTS_CMD_ZERO, `HTS_CMD_ZERO});
        chk("prog exit", 16'h0, {15'h0, prog_mode_o});
        chk("idle before request", 16'h0, {15'h0, meas_busy_o});
        mst.wr_frame(AD, 0, 24'h0);
        chk("busy", 16'h1, {15'h0, meas_busy_o});
        for (int n = 0; n < 40000 && meas_busy_o !== 1'b0; n++) @(posedge clk_i);
        chk("busy end", 16'h0, {15'h0, meas_busy_o});
        // new samples after the cycle must not reach the held result
        hum_raw_i <= 14'h0d31;
        tmp_raw_i <= 14'h3ec4;
        fetch(5, `HTS_STAT_VALID, 14'h2a5c, 14'h1397, 1'b1);
        fetch(2, `HTS_STAT_STALE, 14'h2a5c, 14'h1397, 1'b1);
        fetch(3, `HTS_STAT_STALE, 14'h2a5c, 14'h1397, 1'b1);
        end_sim();
    end
endmodule // hts_top_test
`default_nettype wire

// ===== hw/hts_meas.v
// measurement sequencer: wake, conversions, result update
`timescale 1ns/10ps
`include "hts_regs.vh"
`default_nettype none
module hts_meas (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // control
    input  wire        start_i,
    input  wire [1:0]  hres_i,
    input  wire [1:0]  tres_i,
    // sensor front end samples
    input  wire [13:0] hum_raw_i,
    input  wire [13:0] tmp_raw_i,
    // results
    output reg         busy_o,
    output reg         done_o,
    output reg  [13:0] hum_o,
    output reg  [13:0] tmp_o
);
    reg [20:0] cnt_reg;   // remaining cycles of the cycle

    // half of the equal-resolution total per channel, wake counted once
    function [20:0] half_cyc;
        input [1:0] res;
        reg [31:0] t;
        begin
            case (res)
                2'b00:   t = `HTS_MEAS8_US;
                2'b01:   t = `HTS_MEAS10_US;
                2'b10:   t = `HTS_MEAS12_US;
                default: t = `HTS_MEAS14_US;
            endcase
            // work in 32 bits: the 14-bit product overflows 21 bits
            t        = (t - `HTS_WAKE_US) / 32'd2;
            t        = `HTS_US_CYC(t);
            half_cyc = t[20:0];
        end
    endfunction

    // full cycle count: wake + humidity + temperature
    localparam [31:0] WAKE_CYC = `HTS_US_CYC(`HTS_WAKE_US);  // wake-up in clock cycles
    wire [20:0] total_w = WAKE_CYC[20:0] + half_cyc(hres_i) + half_cyc(tres_i);

    // idle (powered down) until a request, results written at the end
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_o  <= 1'b0;
            done_o  <= 1'b0;
            cnt_reg <= 21'd0;
            hum_o   <= 14'h0000;
            tmp_o   <= 14'h0000;
        end else begin
            done_o <= 1'b0;
            if (!busy_o) begin
                if (start_i) begin
                    busy_o  <= 1'b1;
                    cnt_reg <= total_w;
                end
            end else if (cnt_reg <= 21'd1) begin
                busy_o <= 1'b0;          // powers down after update
                done_o <= 1'b1;
                hum_o  <= hum_raw_i;
                tmp_o  <= tmp_raw_i;
            end else begin
                cnt_reg <= cnt_reg - 21'd1;
            end
        end
    end
endmodule // hts_meas
`default_nettype wire

// ===== hw/hts_regs.vh
// register map, commands and timing constants of the humidity/temperature readout
`ifndef HTS_REGS_VH
`define HTS_REGS_VH
`define HTS_SLAVE_ADDR      7'h44
`define HTS_CMD_PROG_ENTER  8'ha0
`define HTS_CMD_PROG_EXIT   8'h80
`define HTS_CMD_ZERO        8'h00
`define HTS_REG_HRES_RD     8'h06
`define HTS_REG_TRES_RD     8'h11
`define HTS_REG_ID_HI       8'h1e
`define HTS_REG_ID_LO       8'h1f
`define HTS_REG_HRES_WR     8'h46
`define HTS_REG_TRES_WR     8'h51
`define HTS_RES_MSB         11
`define HTS_RES_LSB         10
`define HTS_RES_DEFAULT     2'b11
`define HTS_NVM_RESET       16'h0c00
`define HTS_STAT_VALID      2'b00
`define HTS_STAT_STALE      2'b01
`define HTS_CLK_KHZ         25000
`define HTS_WAKE_US         100
`define HTS_MEAS8_US        1200
`define HTS_MEAS10_US       2720
`define HTS_MEAS12_US       9100
`define HTS_MEAS14_US       33900
`define HTS_PROG_WIN_US     10000
`define HTS_PROG_PROC_US    120
`define HTS_US_CYC(us)      (((us) * `HTS_CLK_KHZ) / 1000)
`endif

// ===== hw/hts_sync.v
// two flip-flop synchroniser for the bus pins
`timescale 1ns/10ps
`default_nettype none
module hts_sync #(
    parameter W = 2
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         rst_n_i,
    // asynchronous in, synchronous out
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] meta_reg;   // first stage, read only by q_o

    // idle bus level is high, so reset to ones
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= {W{1'b1}};
            q_o      <= {W{1'b1}};
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule // hts_sync
`default_nettype wire

// ===== hw/hts_top.v
// i2c slave readout of the humidity/temperature sensor
`timescale 1ns/10ps
`include "hts_regs.vh"
`default_nettype none
// Contract
// - sleep; convert only on measurement request
// - both conversions then result update, sleep
// - results are 14 bits, msb first
// - fetch is address plus read, acknowledged
// - keep sending bytes until master nacks
// - bytes 1-2: status plus humidity
// - bytes 3-4: temperature left aligned
// - measurement times per resolution with wake
// - status 00 when result not fetched
// - status 01 after result fetched
// - stale code before first measurement ends
// - a0 00 within 10ms enters programming
// - entry processed within 120 microseconds
// - non-volatile registers are 16 bits
// - 80 00 00 leaves programming mode
// - humidity resolution read 06, write 46
// - temperature resolution read 11, write 51
// - id halves at 1e and 1f
// - resolution code 00..11, default 14 bits
// - answer only address 44 hex
module hts_top #(
    parameter [31:0] SENSOR_ID   = 32'h5a5a1234,  // arbitrary value
    parameter [31:0] PROG_WIN_CYC = `HTS_US_CYC(`HTS_PROG_WIN_US)
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // i2c pins, open drain
    input  wire        scl_i,
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe_o,
    // sensor front end samples
    input  wire [13:0] hum_raw_i,
    input  wire [13:0] tmp_raw_i,
    // status
    output wire        meas_busy_o,
    output reg         prog_mode_o
);
    localparam [2:0] ST_IDLE = 3'd0;  // waiting for start
    localparam [2:0] ST_ADDR = 3'd1;  // shifting address byte
    localparam [2:0] ST_WACK = 3'd2;  // ack slot: driving ack after the address or a write byte, or idle after a master ack
    localparam [2:0] ST_WR   = 3'd3;  // receiving a write byte
    localparam [2:0] ST_RD   = 3'd4;  // sending a read byte
    localparam [2:0] ST_RACK = 3'd5;  // sampling master ack
    localparam [2:0] ST_SKIP = 3'd6;  // not addressed or fetch nacked, wait for stop

    localparam [31:0] PROC_CYC = `HTS_US_CYC(`HTS_PROG_PROC_US);

    // synchronised pins
    wire [1:0] pin_w;
    wire       scl_w = pin_w[1];
    wire       sda_w = pin_w[0];
    reg        scl_d_reg;            // previous scl
    reg        sda_d_reg;            // previous sda

    reg [2:0]  st_reg;               // bus state
    reg [3:0]  bit_reg;              // bit within byte
    reg [7:0]  sh_reg;               // shift register
    reg        rd_reg;               // transfer is a read
    reg [2:0]  wcnt_reg;             // write bytes this transfer
    reg [7:0]  cmd_reg [0:2];        // captured write bytes
    reg [2:0]  rcnt_reg;             // read byte index
    reg        req_reg;              // bare write seen, request pending
    reg        stale_reg;            // status of current result
    reg [15:0] hres_nv_reg;          // non-volatile humidity word
    reg [15:0] tres_nv_reg;          // non-volatile temperature word
    reg [7:0]  nv_ptr_reg;           // selected register in programming
    reg [31:0] win_reg;              // power-up window counter
    reg [11:0] proc_reg;             // entry processing countdown, 3000 cycles fit
    reg        start_reg;            // pulse to sequencer

    wire       meas_done_w;
    wire [13:0] hum_w;
    wire [13:0] tmp_w;

    // front-end sampling of the bus pins
    hts_sync #(.W(2)) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({scl_i, sda_i}),
        .q_o     (pin_w)
    );

    hts_meas u_meas (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .start_i   (start_reg),
        .hres_i    (hres_nv_reg[`HTS_RES_MSB:`HTS_RES_LSB]),
        .tres_i    (tres_nv_reg[`HTS_RES_MSB:`HTS_RES_LSB]),
        .hum_raw_i (hum_raw_i),
        .tmp_raw_i (tmp_raw_i),
        .busy_o    (meas_busy_o),
        .done_o    (meas_done_w),
        .hum_o     (hum_w),
        .tmp_o     (tmp_w)
    );

    wire scl_rise = scl_w & ~scl_d_reg;
    wire scl_fall = ~scl_w & scl_d_reg;
    wire start_c  = scl_w & scl_d_reg & sda_d_reg & ~sda_w;
    wire stop_c   = scl_w & scl_d_reg & ~sda_d_reg & sda_w;

    // byte served in a read, fetch or register mode
    function [7:0] rd_byte;
        input [2:0] idx;
        input       prog;
        input [7:0] ptr;
        reg   [15:0] w;
        begin
            w = 16'h0000;
            case (ptr)
                `HTS_REG_HRES_RD: w = hres_nv_reg;
                `HTS_REG_TRES_RD: w = tres_nv_reg;
                `HTS_REG_ID_HI:   w = SENSOR_ID[31:16];
                `HTS_REG_ID_LO:   w = SENSOR_ID[15:0];
                default:          w = 16'h0000;
            endcase
            if (prog) begin
                rd_byte = idx[0] ? w[7:0] : w[15:8];
            end else begin
                case (idx)
                    3'd0:    rd_byte = {(stale_reg ? `HTS_STAT_STALE : `HTS_STAT_VALID), hum_w[13:8]};
                    3'd1:    rd_byte = hum_w[7:0];
                    3'd2:    rd_byte = tmp_w[13:6];
                    3'd3:    rd_byte = {tmp_w[5:0], 2'b00};
                    default: rd_byte = 8'h00;                  // beyond four bytes
                endcase
            end
        end
    endfunction

    // edge history of the synchronised pins
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_w;
            sda_d_reg <= sda_w;
        end
    end

    // power-up window timer, stops at PROG_WIN_CYC; entry processing countdown is in the bus engine
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            win_reg  <= 32'd0;
        end else if (win_reg < PROG_WIN_CYC) begin
            win_reg <= win_reg + 32'd1;
        end
    end

    // status of the result: stale at power-up, valid after each cycle
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stale_reg <= 1'b1;
        end else if (meas_done_w) begin
            stale_reg <= 1'b0;
        end else if (st_reg == ST_RACK && scl_rise && !prog_mode_o && rcnt_reg == 3'd0) begin
            stale_reg <= 1'b1;
        end
    end

    // i2c slave engine, command decode and non-volatile registers
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg      <= ST_IDLE;
            bit_reg     <= 4'd0;
            sh_reg      <= 8'h00;
            rd_reg      <= 1'b0;
            wcnt_reg    <= 3'd0;
            cmd_reg[0]  <= 8'h00;
            cmd_reg[1]  <= 8'h00;
            cmd_reg[2]  <= 8'h00;
            rcnt_reg    <= 3'd0;
            req_reg     <= 1'b0;
            sda_o       <= 1'b0;
            sda_oe_o    <= 1'b0;
            prog_mode_o <= 1'b0;
            proc_reg    <= 12'h000;
            nv_ptr_reg  <= 8'h00;
            hres_nv_reg <= `HTS_NVM_RESET;
            tres_nv_reg <= `HTS_NVM_RESET;
            start_reg   <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            if (proc_reg != 12'h000) begin
                proc_reg <= proc_reg - 12'h001;
            end
            if (stop_c || start_c) begin
                sda_oe_o <= 1'b0;
                // transfer end: act on the collected write bytes
                if (wcnt_reg == 3'd0 && req_reg && !prog_mode_o && !meas_busy_o) begin
                    start_reg <= 1'b1;
                end
                if (wcnt_reg == 3'd3 && cmd_reg[0] == `HTS_CMD_PROG_EXIT &&
                    cmd_reg[1] == `HTS_CMD_ZERO && cmd_reg[2] == `HTS_CMD_ZERO) begin
                    prog_mode_o <= 1'b0;
                end else if (wcnt_reg == 3'd3 && prog_mode_o && proc_reg == 12'h000) begin
                    // register write: address then 16-bit word
                    if (cmd_reg[0] == `HTS_REG_HRES_WR) begin
                        hres_nv_reg <= {cmd_reg[1], cmd_reg[2]};
                    end
                    if (cmd_reg[0] == `HTS_REG_TRES_WR) begin
                        tres_nv_reg <= {cmd_reg[1], cmd_reg[2]};
                    end
                end else if (wcnt_reg >= 3'd1 && prog_mode_o && proc_reg == 12'h000) begin
                    nv_ptr_reg <= cmd_reg[0];        // pointer for next read
                end
                if (wcnt_reg == 3'd2 && cmd_reg[0] == `HTS_CMD_PROG_ENTER &&
                    cmd_reg[1] == `HTS_CMD_ZERO && win_reg < PROG_WIN_CYC) begin
                    prog_mode_o <= 1'b1;
                    proc_reg    <= PROC_CYC[11:0];
                end
                req_reg  <= 1'b0;
                wcnt_reg <= 3'd0;
                st_reg   <= start_c ? ST_ADDR : ST_IDLE;
                bit_reg  <= 4'd0;
            end else begin
                case (st_reg)
                    ST_IDLE: begin
                        sda_oe_o <= 1'b0;
                    end
                    ST_ADDR, ST_WR: begin
                        if (scl_rise) begin
                            sh_reg  <= {sh_reg[6:0], sda_w};
                            bit_reg <= bit_reg + 4'd1;
                        end else if (scl_fall && bit_reg == 4'd8) begin
                            bit_reg <= 4'd0;
                            if (st_reg == ST_ADDR) begin
                                if (sh_reg[7:1] == `HTS_SLAVE_ADDR) begin
                                    rd_reg   <= sh_reg[0];
                                    req_reg  <= ~sh_reg[0];
                                    sda_o    <= 1'b0;
                                    sda_oe_o <= 1'b1;
                                    rcnt_reg <= 3'd0;
                                    st_reg   <= ST_WACK;
                                end else begin
                                    st_reg <= ST_SKIP;
                                end
                            end else begin
                                if (wcnt_reg < 3'd3) begin
                                    cmd_reg[wcnt_reg[1:0]] <= sh_reg;
                                    wcnt_reg <= wcnt_reg + 3'd1;
                                end
                                sda_o    <= 1'b0;
                                sda_oe_o <= 1'b1;
                                st_reg   <= ST_WACK;
                            end
                        end
                    end
                    ST_WACK: begin
                        if (scl_fall) begin
                            if (rd_reg) begin
                                // first data bit out right after the ack
                                sh_reg   <= rd_byte(rcnt_reg, prog_mode_o, nv_ptr_reg);
                                sda_o    <= 1'b0;
                                sda_oe_o <= (rd_byte(rcnt_reg, prog_mode_o, nv_ptr_reg) < 8'h80); // low for msb 0
                                bit_reg  <= 4'd1;
                                st_reg   <= ST_RD;
                            end else begin
                                sda_oe_o <= 1'b0;
                                st_reg   <= ST_WR;
                            end
                        end
                    end
                    ST_RD: begin
                        if (scl_fall) begin
                            if (bit_reg == 4'd8) begin
                                sda_oe_o <= 1'b0;                  // release for ack
                                st_reg   <= ST_RACK;
                            end else begin
                                sda_oe_o <= ~sh_reg[3'd7 - bit_reg[2:0]];
                                bit_reg  <= bit_reg + 4'd1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            if (sda_w) begin
                                st_reg <= ST_SKIP;                 // nack ends the fetch
                            end else begin
                                rcnt_reg <= rcnt_reg + 3'd1;
                                st_reg   <= ST_WACK;
                            end
                        end
                    end
                    ST_SKIP: begin
                        sda_oe_o <= 1'b0;
                    end
                    default: st_reg <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // hts_top
`default_nettype wire
